// ---- include/sric_pkg.sv ----
// Purpose: Shared constants and carriers for the self-test and reverse init command block
// Assumes: Commands arrive already deframed with their CRC checked
// Notes: Register offsets are byte addresses on a 32-bit AHB-Lite slave
package sric_pkg;
   // Command codes
   localparam logic [3:0] SRIC_CODE_DIS = 4'hC;
   localparam logic [3:0] SRIC_CODE_EN = 4'hD;
   localparam logic [3:0] SRIC_CODE_RINIT = 4'hF;
   localparam logic [3:0] SRIC_ADDR_GLOBAL = 4'h0;
   localparam logic [3:0] SRIC_FMT_ALL = 4'hF;
   // Register offsets
   localparam logic [7:0] SRIC_OFS_CTRL = 8'h00;
   localparam logic [7:0] SRIC_OFS_FMT = 8'h04;
   localparam logic [7:0] SRIC_OFS_STAT = 8'h08;
   // Reset values
   localparam logic [3:0] SRIC_FMT_RST = 4'h0;
   localparam logic [4:0] SRIC_CTRL_RST = 5'h00;
   // Status flag positions in the response low byte
   localparam int SRIC_FLAG_ARMED = 5;
   // Reverse init data byte fields
   localparam int SRIC_RI_MEM = 7;
   localparam int SRIC_RI_CLOSE = 6;
   localparam int SRIC_RI_OPT_HI = 5;
   localparam int SRIC_RI_OPT_LO = 4;
   localparam int SRIC_RI_ID_HI = 3;
   // Bus blanking time after a switch close
   localparam int SRIC_BLANK_TIME_NS = 180000;
   localparam int SRIC_CLK_PERIOD_NS = 25;
   localparam int SRIC_BLANK_CYCLES = SRIC_BLANK_TIME_NS / SRIC_CLK_PERIOD_NS;
   localparam int SRIC_CNT_W = 16;

   typedef enum logic [1:0] {
      SRIC_IDLE = 2'b00,
      SRIC_EXEC = 2'b01,
      SRIC_RESP = 2'b11
   } sric_state_e;

   // Deframed command from the bus receiver
   typedef struct packed {
      logic is_long;
      logic crc_ok;
      logic on_cmd_port;
      logic [3:0] short_len;
      logic [3:0] addr;
      logic [3:0] code;
      logic [7:0] data;
   } sric_cmd_s;

   // Response to the bus transmitter; long frames are 16 bits
   typedef struct packed {
      logic is_long;
      logic [3:0] len;
      logic [15:0] data;
   } sric_resp_s;
endpackage : sric_pkg

// ---- src/sric_cmd.sv ----
// Purpose: Self-test enable/disable and reverse initialization command handling
// Assumes: One command presented at a time with cmd_valid_in/cmd_ready_out
// Notes: Status flags come from sensing logic; registers sit on AHB-Lite
// Operation
// [RULE1] Disable runs for own or global address
// [RULE2] Two consecutive disables enter lockout
// [RULE3] Lockout holds stimulus off until clear
// [RULE4] Enable accepted in long or short frame
// [RULE5] Data ignored, still covered by CRC
// [RULE6] Global enable does nothing
// [RULE7] Long response: address, zeros, eight flags
// [RULE8] Short response: flags low, zeros above
// [RULE9] Lockout reports armed flag as zero; code clears it only in enable responses, disable responses send the live flag
// [RULE10] Enhanced features only after init and format
// [RULE11] Master sends reverse init long, code F
// [RULE12] Reverse init data byte field layout
// [RULE13] Reverse init only on command port side
// [RULE14] Test switched side, set line fault
// [RULE15] Close switch if no fault and requested
// [RULE16] Programmed: both addresses must match it
// [RULE17] Unprogrammed: take proposed id, address zero
// [RULE18] Failed addressing: no address, no response
// [RULE19] Ignore bus level 180 us after close
// [RULE20] Reverse init response field layout
// [RULE21] Response echoes newly assigned address twice
// [RULE22] Never assign node address zero
// [RULE23] Format takes effect only when written 1111
// [RULE24] Flags sampled when response is built
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module sric_cmd #(
   parameter int BLANK_CYCLES = sric_pkg::SRIC_BLANK_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic [31:0] hrdata_out,
   input wire logic cmd_valid_in,
   input wire sric_pkg::sric_cmd_s cmd_in,
   output logic cmd_ready_out,
   input wire logic clear_cmd_in,
   input wire logic [7:0] status_flags_in,
   input wire logic batt_short_in,
   output logic resp_valid_out,
   output sric_pkg::sric_resp_s resp_out,
   output logic stim_enable_out,
   output logic lockout_out,
   output logic switch_closed_out,
   output logic bus_blank_out,
   output logic enhanced_out,
   output logic [3:0] node_addr_out
);
   import sric_pkg::*;

   sric_state_e state;
   sric_state_e next_state;
   sric_cmd_s cmd_q;
   logic [3:0] node_addr;
   logic addr_valid;
   logic init_done;
   logic last_dis;
   logic line_fault;
   logic resp_init;
   logic resp_en;
   logic [SRIC_CNT_W-1:0] blank_cnt;
   logic [SRIC_CNT_W-1:0] next_blank_cnt;
   logic [3:0] fmt_sel;
   logic otp_prog;
   logic [3:0] otp_addr;
   logic wr_pend;
   logic [7:0] wr_addr;

   // Command decode of the captured frame; data byte is never looked at here
   wire is_dis = cmd_q.code == SRIC_CODE_DIS;
   wire is_en = cmd_q.code == SRIC_CODE_EN;
   wire is_rinit = cmd_q.code == SRIC_CODE_RINIT;
   wire is_global = cmd_q.addr == SRIC_ADDR_GLOBAL;
   wire to_me = addr_valid && (cmd_q.addr == node_addr);
   // Short frames are a 2.0 feature, refused until enhanced mode is live
   wire frame_ok = cmd_q.crc_ok && (cmd_q.is_long || enhanced_out); // [RULE4] [RULE5] [RULE10]
   wire in_exec = state == SRIC_EXEC;
   wire exec_dis = in_exec && frame_ok && is_dis && (to_me || is_global); // [RULE1]
   wire exec_en = in_exec && frame_ok && is_en && to_me && !is_global; // [RULE6]
   wire any_cmd = in_exec && cmd_q.crc_ok;

   // Reverse init addressing checks
   wire [3:0] prop_id = cmd_q.data[SRIC_RI_ID_HI:0];
   wire is_prog = otp_prog || addr_valid;
   wire [3:0] prog_addr = otp_prog ? otp_addr : node_addr;
   wire match_prog = (prop_id == prog_addr) && (cmd_q.addr == prog_addr); // [RULE16]
   wire match_new = cmd_q.addr == SRIC_ADDR_GLOBAL; // [RULE17]
   wire addr_ok = (is_prog ? match_prog : match_new) && (prop_id != 4'h0); // [RULE22]
   // Only a 1.1 long frame seen on the command port side counts
   wire rinit_frame = cmd_q.is_long && cmd_q.crc_ok && cmd_q.on_cmd_port && is_rinit; // [RULE11] [RULE13]
   wire rinit_ok = in_exec && rinit_frame && addr_ok; // [RULE18]
   wire close_req = cmd_q.data[SRIC_RI_CLOSE]; // [RULE12]
   wire do_close = rinit_ok && close_req && !batt_short_in; // [RULE15]
   wire do_blank = rinit_ok && close_req; // [RULE19]
   wire want_resp = (exec_dis && !is_global) || exec_en || rinit_ok; // [RULE18]

   // Lockout: the set wins over a clear arriving in the same cycle
   // Stimulus enable is forced off under lockout, else follows the last disable or enable that really ran
   wire set_lock = exec_dis && last_dis; // [RULE2]
   wire next_lock = set_lock || (lockout_out && !clear_cmd_in); // [RULE3]
   wire next_stim = next_lock ? 1'b0 : (exec_en ? 1'b1 : (exec_dis ? 1'b0 : stim_enable_out));

   // Response build from flags sampled now
   wire [7:0] flags_en = {status_flags_in[7:6], 1'b0, status_flags_in[4:0]};
   wire [7:0] flags = (resp_en && lockout_out) ? flags_en : status_flags_in; // [RULE9] [RULE24]
   wire [15:0] st_long = {node_addr, 4'h0, flags}; // [RULE7]
   wire [15:0] st_short = {8'h00, flags}; // [RULE8]
   wire [15:0] ri_word = {node_addr, 3'b000, line_fault,
      cmd_q.data[SRIC_RI_MEM], cmd_q.data[SRIC_RI_CLOSE],
      cmd_q.data[SRIC_RI_OPT_HI:SRIC_RI_OPT_LO], node_addr}; // [RULE20] [RULE21]
   wire [15:0] rsp_word = resp_init ? ri_word : (cmd_q.is_long ? st_long : st_short);
   wire in_resp = state == SRIC_RESP;

   // Blanking counter load and run-down
   // A new close request restarts the window rather than adding to it
   always_comb begin
      next_blank_cnt = blank_cnt;
      if (do_blank) begin
         next_blank_cnt = BLANK_CYCLES[SRIC_CNT_W-1:0];
      end else if (blank_cnt != '0) begin
         next_blank_cnt = blank_cnt - 1'b1;
      end
   end

   // Sequencer: capture, execute, respond
   // No command is taken while a response is still being built
   always_comb begin
      next_state = state;
      case (state)
         SRIC_IDLE: begin
            if (cmd_valid_in && cmd_ready_out) begin
               next_state = SRIC_EXEC;
            end
         end
         SRIC_EXEC: begin
            next_state = want_resp ? SRIC_RESP : SRIC_IDLE;
         end
         SRIC_RESP: begin
            next_state = SRIC_IDLE;
         end
         default: begin
            next_state = SRIC_IDLE;
         end
      endcase
   end

   // State and command capture
   // Ready is registered, so it drops at the edge that takes a command
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= SRIC_IDLE;
         cmd_q <= '0;
         cmd_ready_out <= 1'b0;
      end else begin
         state <= next_state;
         cmd_ready_out <= next_state == SRIC_IDLE;
         if (state == SRIC_IDLE && cmd_valid_in && cmd_ready_out) begin
            cmd_q <= cmd_in;
         end
      end
   end

   // Self-test control and lockout
   // Only good-CRC frames count when judging back to back disables
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lockout_out <= 1'b0;
         stim_enable_out <= 1'b0;
         last_dis <= 1'b0;
      end else begin
         lockout_out <= next_lock;
         stim_enable_out <= next_stim; // [RULE3]
         if (any_cmd) begin
            last_dis <= exec_dis; // [RULE2]
         end
      end
   end

   // Addressing, bus switch and line fault
   // Once closed the switch stays shut; a later fault only shows in the flag
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         node_addr <= 4'h0;
         addr_valid <= 1'b0;
         init_done <= 1'b0;
         line_fault <= 1'b0;
         switch_closed_out <= 1'b0;
      end else if (rinit_ok) begin
         node_addr <= prop_id; // [RULE21]
         addr_valid <= 1'b1;
         init_done <= 1'b1;
         line_fault <= batt_short_in; // [RULE14]
         switch_closed_out <= switch_closed_out || do_close; // [RULE15]
      end
   end

   // Bus level blanking
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         blank_cnt <= '0;
         bus_blank_out <= 1'b0;
      end else begin
         blank_cnt <= next_blank_cnt;
         bus_blank_out <= next_blank_cnt != '0; // [RULE19]
      end
   end

   // Response kind latch and output frame
   // Kind bits are latched in EXEC since the execute strobes are gone in RESP
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         resp_init <= 1'b0;
         resp_en <= 1'b0;
         resp_valid_out <= 1'b0;
         resp_out <= '0;
      end else begin
         if (in_exec) begin
            resp_init <= rinit_ok;
            resp_en <= exec_en;
         end
         resp_valid_out <= in_resp;
         if (in_resp) begin
            resp_out.is_long <= cmd_q.is_long || resp_init;
            resp_out.len <= cmd_q.short_len;
            resp_out.data <= rsp_word; // [RULE24]
         end
      end
   end

   // Enhanced mode needs a completed init and an all-ones format selection
   // Both conditions only move one way, so the flag never drops before reset
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enhanced_out <= 1'b0;
         node_addr_out <= 4'h0;
      end else begin
         enhanced_out <= init_done && (fmt_sel == SRIC_FMT_ALL); // [RULE10] [RULE23]
         node_addr_out <= node_addr;
      end
   end

   // AHB-Lite address phase decode; zero wait states, always OKAY
   // Unmapped offsets read as zero so software can probe the map safely
   wire ahb_go = hsel_in && htrans_in[1] && hready_in;
   wire [7:0] a_ofs = haddr_in[7:0];
   wire [31:0] stat_word = {20'h00000, node_addr, enhanced_out, bus_blank_out,
      line_fault, switch_closed_out, stim_enable_out, lockout_out, init_done, addr_valid};
   wire [31:0] rd_word = (a_ofs == SRIC_OFS_CTRL) ? {27'h0000000, otp_addr, otp_prog} :
      (a_ofs == SRIC_OFS_FMT) ? {28'h0000000, fmt_sel} :
      (a_ofs == SRIC_OFS_STAT) ? stat_word : 32'h00000000;
   wire wr_ctrl = wr_pend && (wr_addr == SRIC_OFS_CTRL);
   wire wr_fmt = wr_pend && (wr_addr == SRIC_OFS_FMT);
   // A partial pattern never drops the format back to standard
   wire fmt_hit = hwdata_in[3:0] == SRIC_FMT_ALL; // [RULE23]

   // Bus slave registers; hsize is ignored since only full words are used
   // Write data is taken one cycle after its address phase, as the bus defines
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         hrdata_out <= 32'h00000000;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         {otp_addr, otp_prog} <= SRIC_CTRL_RST;
         fmt_sel <= SRIC_FMT_RST;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         wr_pend <= ahb_go && hwrite_in;
         if (ahb_go) begin
            wr_addr <= a_ofs;
         end
         if (ahb_go && !hwrite_in) begin
            hrdata_out <= rd_word;
         end
         if (wr_ctrl) begin
            {otp_addr, otp_prog} <= hwdata_in[4:0];
         end
         if (wr_fmt && fmt_hit) begin
            fmt_sel <= SRIC_FMT_ALL;
         end
      end
   end

   // Checks of the command behaviour
   AST_LOCK_CAUSE: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE2]
      $rose(lockout_out) |-> $past(exec_dis) && $past(last_dis))
      else $error("lockout set without two consecutive disables");
   AST_LOCK_STIM: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE3]
      lockout_out |-> !stim_enable_out)
      else $error("stimulus on during lockout");
   AST_GLOBAL_EN: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE6]
      in_exec && is_en && is_global |=> state == SRIC_IDLE && $stable(stim_enable_out))
      else $error("global enable had an effect");
   AST_LONG_ZERO: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE7]
      resp_valid_out && !resp_init && resp_out.is_long |-> resp_out.data[11:8] == 4'h0)
      else $error("long self-test response bits 11..8 not zero");
   AST_SHORT_ZERO: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE8]
      resp_valid_out && !resp_out.is_long |-> resp_out.data[15:8] == 8'h00)
      else $error("short response upper bits not zero");
   AST_ARMED_ZERO: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE9]
      resp_valid_out && resp_en && $past(lockout_out) |-> !resp_out.data[SRIC_FLAG_ARMED])
      else $error("armed flag reported during lockout");
   AST_ENH_INIT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE10]
      enhanced_out |-> init_done && fmt_sel == SRIC_FMT_ALL)
      else $error("enhanced mode without init and format");
   AST_CLOSE_OK: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE15]
      $rose(switch_closed_out) |-> !line_fault && $past(close_req))
      else $error("switch closed with fault or without request");
   AST_BLANK_HOLD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE19]
      $rose(bus_blank_out) |-> bus_blank_out [*8])
      else $error("blanking ended too soon");
   AST_NO_ZERO: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE22]
      addr_valid |-> node_addr != 4'h0)
      else $error("node address zero assigned");
   AST_RI_ECHO: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE21]
      resp_valid_out && resp_init |-> resp_out.data[15:12] == resp_out.data[3:0])
      else $error("reverse init address fields differ");

   // Execution effects of each self-test command kind
   AST_DIS_RUN: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE1]
      exec_dis |=> !stim_enable_out)
      else $error("stimulus left on after disable");
   AST_LOCK_HOLD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE3]
      lockout_out && !clear_cmd_in |=> lockout_out)
      else $error("lockout dropped without clear");
   AST_EN_RUN: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE4]
      exec_en && !next_lock |=> stim_enable_out)
      else $error("enable did not switch stimulus on");
   AST_SHORT_REFUSE: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE10]
      in_exec && !cmd_q.is_long && !enhanced_out
      |=> state == SRIC_IDLE && $stable(stim_enable_out))
      else $error("short frame acted on before enhanced mode");

   // Reverse init port, addressing and blanking
   AST_RI_PORT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE13]
      in_exec && is_rinit && !cmd_q.on_cmd_port
      |=> $stable(node_addr) && $stable(switch_closed_out))
      else $error("reverse init taken off the command port side");
   AST_FAULT_SET: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE14]
      rinit_ok |=> line_fault == $past(batt_short_in))
      else $error("line fault not taken from the switched side");
   AST_PROG_MATCH: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE16]
      in_exec && rinit_frame && is_prog && cmd_q.addr != prog_addr
      |=> state == SRIC_IDLE && $stable(node_addr))
      else $error("programmed device accepted a foreign address");
   AST_NEW_ADDR: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE17]
      rinit_ok && !is_prog |=> addr_valid && node_addr == $past(prop_id))
      else $error("proposed id not taken as node address");
   AST_NO_RESP: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE18]
      in_exec && rinit_frame && !addr_ok |=> state == SRIC_IDLE && $stable(switch_closed_out))
      else $error("failed addressing still acted");
   AST_BLANK_LOAD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE19]
      do_blank |=> bus_blank_out)
      else $error("blanking not started on close request");

   // Response framing and format selection
   AST_RI_FAULT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE20]
      resp_valid_out && resp_init |->
      resp_out.data[11:9] == 3'h0 && resp_out.data[8] == line_fault)
      else $error("reverse init response fault field wrong");
   AST_EN_ADDR: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE7]
      resp_valid_out && !resp_init && resp_out.is_long |-> resp_out.data[15:12] == node_addr)
      else $error("long self-test response address wrong");
   AST_FMT_PARTIAL: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RULE23]
      wr_fmt && !fmt_hit && fmt_sel != SRIC_FMT_ALL |=> fmt_sel == SRIC_FMT_RST)
      else $error("partial format pattern changed the selection");
endmodule : sric_cmd

// ---- dv/sric_master_model.sv ----
// Purpose: Bus master model that hands deframed commands to the block
// Assumes: One command in flight; held until the ready handshake
// Notes: Released command lines show the inverse of the last value
`timescale 1ns/1ps
module sric_master_model
import sric_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic go_in,
   input wire sric_pkg::sric_cmd_s cmd_in,
   input wire logic ready_in,
   output logic valid_out,
   output sric_pkg::sric_cmd_s cmd_out,
   output logic taken_out
);
   // Hold request until taken; stale data never looks valid
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         valid_out <= 1'b0;
         cmd_out <= '0;
         taken_out <= 1'b0;
      end else begin
         taken_out <= valid_out & ready_in;
         if (valid_out & ready_in) begin
            valid_out <= 1'b0;
            cmd_out <= ~cmd_out; // Released lines toggle
         end else if (go_in & !valid_out) begin
            valid_out <= 1'b1;
            cmd_out <= cmd_in;
         end
      end
   end
endmodule : sric_master_model

// ---- dv/selftest_and_reverse_init_cmd_tb_top.sv ----
// Purpose: Self-checking bench for the self-test and reverse init block
// Assumes: Short blanking count so the run stays brief
// Notes: Seeded random flags, ids and data with fixed corner cases
`timescale 1ns/1ps
module selftest_and_reverse_init_cmd_tb_top;
   import sric_pkg::*;
   localparam int BLK = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hrdy, hresp, go = 1'b0, cmd_v, rdy, taken, clr = 1'b0, bshort = 1'b0, rv;
   logic stim, lock, sw, blank, enh;
   logic [31:0] hrdata, rd;
   logic [7:0] flags = 8'h00;
   logic [7:0] fl;
   logic [3:0] naddr, id;
   sric_cmd_s cmd_req = '0;
   sric_cmd_s cmd_bus;
   sric_cmd_s c;
   sric_resp_s rsp, cap;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   int resp_cnt = 0;
   // 25 ns clock
   always #12.5 clk = ~clk;
   sric_cmd #(.BLANK_CYCLES(BLK)) dut (.core_clk_in(clk), .arst_n_in(rst_n), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
      .hrdata_out(hrdata), .cmd_valid_in(cmd_v), .cmd_in(cmd_bus), .cmd_ready_out(rdy),
      .clear_cmd_in(clr), .status_flags_in(flags), .batt_short_in(bshort),
      .resp_valid_out(rv), .resp_out(rsp), .stim_enable_out(stim), .lockout_out(lock),
      .switch_closed_out(sw), .bus_blank_out(blank), .enhanced_out(enh),
      .node_addr_out(naddr));
   sric_master_model mst (.core_clk_in(clk), .arst_n_in(rst_n), .go_in(go), .cmd_in(cmd_req),
      .ready_in(rdy), .valid_out(cmd_v), .cmd_out(cmd_bus), .taken_out(taken));
   // Catch the one-cycle response pulse; timeout guards any hang
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rv === 1'b1) begin
         resp_cnt <= resp_cnt + 1;
         cap <= rsp;
      end
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         stop_test();
      end
   end
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic miss(input logic [31:0] g, input logic [31:0] e);
      check_count = check_count + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : miss
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      miss(g, e);
   endtask : chk_val
   // Response count (exactly one when due), frame kind and payload
   task automatic chk_resp(input logic [1:0] got, input logic due, input logic lg,
      input logic [15:0] e);
      miss(due ? {13'h0, got, cap.is_long, cap.data} : {30'h0, got}, due ? {13'h0, 2'h1,
         lg, e} : 32'h0);
   endtask : chk_resp
   // AHB-Lite single word transfer, zero-wait not assumed
   task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, ofs};
      hwrite <= wr;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
      chk_val(hresp, 32'h0);
      repeat (2) @(posedge clk);
      #1;
   endtask : ahb
   function automatic sric_cmd_s mk(input logic lg, input logic pt, input logic [3:0] a,
      input logic [3:0] cd, input logic [7:0] d);
      mk = '{lg, 1'b1, pt, 4'hB, a, cd, d};
   endfunction : mk
   function automatic logic [15:0] ri(input logic [3:0] a, input logic f, input logic [7:0] d);
      ri = {a, 3'h0, f, d[7:4], a};
   endfunction : ri
   task automatic send(input sric_cmd_s k, input logic due, input logic [15:0] e);
      int n0;
      n0 = resp_cnt;
      @(posedge clk);
      cmd_req <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(negedge clk); while (taken !== 1'b1);
      repeat (4) @(posedge clk);
      #1;
      chk_resp(2'(resp_cnt - n0), due, k.is_long, e);
   endtask : send
   initial begin
      void'($urandom(33291));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      // Reset state and register map
      ahb(1'b0, SRIC_OFS_CTRL, 32'h0);
      chk_val(rd, 32'h0);
      ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h0C, 32'h0);
      chk_val(rd, 32'h0);
      chk_val({stim, lock, sw, blank, enh, naddr}, 32'h0);
      $display("test reset done");
      // Reverse init refusals
      id = 4'(1 + $urandom % 15);
      fl = 8'($urandom) | 8'h20;
      send(mk(1'b1, 1'b1, 4'h0, SRIC_CODE_RINIT, 8'hC0), 1'b0, 16'h0);
      send(mk(1'b1, 1'b0, 4'h0, SRIC_CODE_RINIT, {4'hC, id}), 1'b0, 16'h0);
      send(mk(1'b1, 1'b1, id, SRIC_CODE_RINIT, {4'hC, id}), 1'b0, 16'h0);
      chk_val({sw, naddr}, 32'h0);
      // Address assignment with switch close
      c = mk(1'b1, 1'b1, 4'h0, SRIC_CODE_RINIT, {4'hD, id});
      send(c, 1'b1, ri(id, 1'b0, c.data));
      chk_val({sw, naddr}, {27'h0, 1'b1, id});
      chk_val(blank, 32'h1);
      repeat (BLK + 5) @(posedge clk);
      #1;
      chk_val(blank, 32'h0);
      ahb(1'b0, SRIC_OFS_STAT, 32'h0);
      chk_val(rd, {20'h0, id, 8'h13});
      // Programmed device: mismatch, then line fault
      @(posedge clk) bshort <= 1'b1;
      send(mk(1'b1, 1'b1, id ^ 4'h1, SRIC_CODE_RINIT, {4'h0, id}), 1'b0, 16'h0);
      c = mk(1'b1, 1'b1, id, SRIC_CODE_RINIT, {4'h0, id});
      send(c, 1'b1, ri(id, 1'b1, c.data));
      @(posedge clk) bshort <= 1'b0;
      $display("test reverse init done");
      // Enable in long form, global, and short before format
      @(posedge clk) flags <= fl;
      send(mk(1'b1, 1'b1, id, SRIC_CODE_EN, 8'($urandom)), 1'b1, {id, 4'h0, fl});
      send(mk(1'b1, 1'b1, 4'h0, SRIC_CODE_EN, 8'h00), 1'b0, 16'h0);
      send(mk(1'b0, 1'b1, id, SRIC_CODE_EN, 8'h00), 1'b0, 16'h0);
      ahb(1'b1, SRIC_OFS_FMT, 32'h7);
      chk_val(enh, 32'h0);
      ahb(1'b1, SRIC_OFS_FMT, 32'hF);
      chk_val(enh, 32'h1);
      c = mk(1'b0, 1'b1, id, SRIC_CODE_EN, 8'($urandom));
      c.short_len = 4'(8 + $urandom % 8);
      send(c, 1'b1, {8'h00, fl});
      chk_val(cap.len, c.short_len);
      $display("test enable done");
      // Two disables lock out the stimulus
      send(mk(1'b1, 1'b1, id, SRIC_CODE_DIS, 8'h5A), 1'b1, {id, 4'h0, fl});
      chk_val(lock, 32'h0);
      send(mk(1'b0, 1'b1, id, SRIC_CODE_DIS, 8'hA5), 1'b1, {8'h00, fl});
      chk_val({lock, stim}, 32'h2);
      send(mk(1'b1, 1'b1, id, SRIC_CODE_EN, 8'h00), 1'b1, {id, 4'h0, fl & 8'hDF});
      chk_val({lock, stim}, 32'h2);
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk_val(lock, 32'h0);
      // Global disable executes silently
      send(mk(1'b1, 1'b1, id, SRIC_CODE_EN, 8'h00), 1'b1, {id, 4'h0, fl});
      chk_val(stim, 32'h1);
      send(mk(1'b1, 1'b1, 4'h0, SRIC_CODE_DIS, 8'h00), 1'b0, 16'h0);
      chk_val({lock, stim}, 32'h0);
      $display("test lockout done");
      stop_test();
   end
endmodule : selftest_and_reverse_init_cmd_tb_top
